// [pms_checker.sv]
// Port-level property checker for the power mode sequencer
`timescale 1ns/1ps
module pms_checker (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_supply_good,
  input wire logic o_adapter_valid,
  input wire logic o_converter_run,
  input wire logic o_charger_gate,
  input wire logic o_charge_current_request,
  input wire logic [2:0] o_mode
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic chg_en;
  logic boot;
  logic no_chg;
  assign chg_en = o_mode == 3'h4 || o_mode == 3'h5;
  assign boot = o_mode == 3'h2;
  // Off, mask, boot and battery-only modes never feed the charger
  assign no_chg = o_mode inside {3'h1, 3'h2, 3'h3, 3'h6};
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_idle_held: assert property (!o_supply_good [*2] |-> o_mode == 3'h0)
    else $error("mode left idle while supply is low");
  a_off_on_good: assert property ($rose(o_supply_good) |-> ##[1:2] o_mode == 3'h1)
    else $error("no off mode after supply good");
  a_boot_length: assert property ($rose(boot) |-> ##99 boot ##1 !boot)
    else $error("boot check not 100 cycles");
  a_boot_start: assert property (o_mode == 3'h1 && o_adapter_valid |-> ##[1:2] boot)
    else $error("adapter did not start boot");
  a_off_holds: assert property ((o_mode == 3'h1 && !o_adapter_valid) [*8] |=>
    o_mode == 3'h1 || o_mode == 3'h2 || !o_supply_good)
    else $error("off mode left without cause");
  a_run_modes: assert property ($stable(o_mode) [*2] |->
    o_converter_run == (o_mode == 3'h5 || o_mode == 3'h6))
    else $error("converter run does not match mode");
  a_gate_blocked: assert property ((!o_adapter_valid || !chg_en) [*2] |-> o_charger_gate)
    else $error("charger gate active without charging");
  a_gate_period: assert property ($rose(o_charger_gate) && chg_en |-> ##100
    ($rose(o_charger_gate) || !chg_en || !o_adapter_valid))
    else $error("charger gate period not 100 cycles");
  a_req_disabled: assert property (no_chg [*2] |-> o_charge_current_request)
    else $error("current request not disabled");
  a_rdata_quiet: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read answer");
  // Coverage of main modes
  c_charge: cover property (o_mode == 3'h4 ##1 o_mode == 3'h4);
  c_mask: cover property (o_mode == 3'h3);
  c_opchg: cover property (o_mode == 3'h5 ##1 o_mode == 3'h6);
  c_lowbat: cover property (o_mode == 3'h6 ##[1:30] o_mode == 3'h1);
endmodule

bind pms_top pms_checker u_chk (.i_ref_clk, .i_sys_rst, .i_rd, .o_rdata,
  .o_supply_good, .o_adapter_valid, .o_converter_run, .o_charger_gate,
  .o_charge_current_request, .o_mode);

// [pms_partner.sv]
// Model of the power chip comparators and battery voltage sampler
`timescale 1ns/1ps
module pms_partner (
  input wire logic i_ref_clk,
  input wire logic [11:0] i_rail_mv,
  input wire logic [7:0] i_adapter_dv,
  input wire logic [9:0] i_bat_cv,
  input wire logic i_bat_fitted,
  output logic o_backup_rail_ok,
  output logic o_adapter_ok,
  output logic o_battery_present,
  output logic o_batv_valid,
  output logic [9:0] o_battery_voltage_sense
);
  // ----------------------------------------------------------------
  // Comparators and sampler
  // ----------------------------------------------------------------
  logic [3:0] tick = 4'h0;
  always_ff @(posedge i_ref_clk) begin
    tick <= tick + 4'h1;
  end
  assign o_backup_rail_ok = i_rail_mv > 12'hBEA;
  assign o_adapter_ok = i_adapter_dv >= 8'h64;
  assign o_battery_present = i_bat_fitted;
  // One sample every 16 cycles; scrambled between, so stale use shows
  assign o_batv_valid = tick == 4'h0;
  assign o_battery_voltage_sense = o_batv_valid ? i_bat_cv : ~i_bat_cv;
endmodule

// [pms_pkg.sv]
// Constants and types of the power mode sequencer
package pms_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int GATE_HZ = 100_000;
  localparam int DEB_MS = 20;
  localparam int FLY_MS = 5;
  localparam int BOOT_US = 10;
  localparam int MONTH3_DAYS = 90;
  localparam int REFRESH_H = 16;
  localparam int FAST_H = 6;
  localparam int TOPOFF_H = 2;
  localparam int TRICKLE_H = 48;
  localparam logic [23:0] BOOT_CYC = 24'(CLK_HZ / 1_000_000 * BOOT_US);
  localparam logic [6:0] GATE_TOP = 7'(CLK_HZ / GATE_HZ - 1);
  localparam logic [6:0] DUTY_RST = 7'h32;
  // ----------------------------------------------------------------
  // Levels: request in 0.1 V steps of 3.3 V, battery in 10 mV codes
  // ----------------------------------------------------------------
  localparam logic [5:0] REQ_TOP = 6'h20;
  localparam logic [5:0] REQ_FAST = 6'h00;
  localparam logic [5:0] REQ_TOPOFF = 6'h0F;
  localparam logic [5:0] REQ_TRICKLE = 6'h17;
  localparam logic [5:0] REQ_NONE = 6'h1B;
  localparam logic [5:0] REQ_OFF = 6'h21;
  localparam logic [9:0] BATV_LOW = 10'h190;
  localparam logic [9:0] BATV_FAST = 10'h208;
  localparam logic [9:0] DV_DROP = 10'h002;
  localparam logic [7:0] CYCLES_MAX = 8'h32;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_PCYC = 4'h8;
  localparam logic [3:0] ADDR_DUTY = 4'hC;
  localparam int CTRL_START = 0;
  localparam int CTRL_ACK = 1;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_OFF = 3'b001, M_BOOT = 3'b010, M_MASK = 3'b011,
    M_CHARGE = 3'b100, M_OPCHG = 3'b101, M_OPER = 3'b110
  } pms_mode_e;
  typedef enum logic [2:0] {
    C_OFF = 3'b000, C_FAST = 3'b001, C_TOPOFF = 3'b010,
    C_TRICKLE = 3'b011, C_DONE = 3'b100
  } pms_chg_e;
  typedef enum logic [1:0] {
    R_NONE = 2'b00, R_CHG1 = 2'b01, R_DIS = 2'b10, R_CHG2 = 2'b11
  } pms_ref_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [23:0] cnt;
  } pms_sync_s;
  typedef struct packed {
    logic sg;
    logic av;
    logic on;
    logic key_q;
    logic bp_q;
    pms_mode_e mode;
    logic [23:0] tmr;
    logic [23:0] sec_cnt;
    logic prompt;
    logic pend;
    logic [7:0] pcyc;
    logic [23:0] month;
    pms_ref_e rf;
    logic [23:0] ref_cnt;
    pms_chg_e chg;
    logic [23:0] chg_cnt;
    logic [9:0] peak;
    logic [6:0] duty;
    logic [6:0] gcnt;
    logic gate;
    logic [5:0] rcnt;
    logic req;
    logic run;
    logic [15:0] rdata;
  } pms_top_s;
endpackage

// [pms_sync.sv]
// Two-stage synchroniser with optional debounce filter
`timescale 1ns/1ps
module pms_sync #(
  parameter logic [23:0] DEB_CYC = 24'h000001
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_level
);
  pms_pkg::pms_sync_s s;
  pms_pkg::pms_sync_s n;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Only the second stage feeds the filter, never the first
  always_comb begin
    n = s;
    n.s1 = i_async;
    n.s2 = s.s1;
    if (s.s2 == s.level) begin
      n.cnt = '0;
    end else if (s.cnt >= DEB_CYC - 24'h1) begin
      n.level = s.s2;
      n.cnt = '0;
    end else begin
      n.cnt = s.cnt + 24'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_level = s.level;
endmodule

// [pms_top.sv]
// Power mode sequencer: supply supervision, modes, charging, refresh
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module pms_top #(
  parameter logic [23:0] DEB_CYC = 24'(pms_pkg::CLK_HZ / 1000 *
                                        pms_pkg::DEB_MS),
  parameter logic [23:0] FLY_CYC = 24'(pms_pkg::CLK_HZ / 1000 *
                                        pms_pkg::FLY_MS),
  parameter logic [23:0] SEC_CYC = 24'(pms_pkg::CLK_HZ),
  parameter logic [23:0] MONTH3_S = 24'(pms_pkg::MONTH3_DAYS * 86400),
  parameter logic [23:0] REFRESH_S = 24'(pms_pkg::REFRESH_H * 3600),
  parameter logic [23:0] FAST_S = 24'(pms_pkg::FAST_H * 3600),
  parameter logic [23:0] TOPOFF_S = 24'(pms_pkg::TOPOFF_H * 3600),
  parameter logic [23:0] TRICKLE_S = 24'(pms_pkg::TRICKLE_H * 3600)
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_backup_rail_ok,
  input wire logic i_adapter_ok,
  input wire logic i_onoff_key,
  input wire logic i_key_up,
  input wire logic i_key_right,
  input wire logic i_battery_present,
  input wire logic i_firmware_valid,
  input wire logic i_batv_valid,
  input wire logic [9:0] i_battery_voltage_sense,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_supply_good,
  output logic o_adapter_valid,
  output logic o_converter_run,
  output logic o_charger_gate,
  output logic o_charge_current_request,
  output logic o_refresh_prompt,
  output logic [2:0] o_mode
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic bk_ok;
  logic ad_ok;
  logic key;
  logic up;
  logic right;
  logic bat_in;

  pms_sync #(.DEB_CYC(24'h000001)) u_bk (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_backup_rail_ok), .o_level(bk_ok));
  pms_sync #(.DEB_CYC(24'h000001)) u_ad (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_adapter_ok), .o_level(ad_ok));
  pms_sync #(.DEB_CYC(DEB_CYC)) u_key (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_onoff_key), .o_level(key));
  pms_sync #(.DEB_CYC(DEB_CYC)) u_up (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_key_up), .o_level(up));
  pms_sync #(.DEB_CYC(DEB_CYC)) u_rt (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_key_right), .o_level(right));
  pms_sync #(.DEB_CYC(DEB_CYC)) u_bat (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_battery_present), .o_level(bat_in));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam pms_pkg::pms_top_s RST = '{
    mode: pms_pkg::M_IDLE, rf: pms_pkg::R_NONE, chg: pms_pkg::C_OFF,
    duty: pms_pkg::DUTY_RST, gate: 1'b1, req: 1'b1, default: '0};

  pms_pkg::pms_top_s s;
  pms_pkg::pms_top_s n;
  logic sec;
  logic press;
  logic smp;
  logic low;
  logic enter;
  logic part;
  logic start;
  logic chg_en;
  logic [9:0] v;
  logic [5:0] level;

  always_comb begin
    n = s;
    n.sg = bk_ok;
    n.av = ad_ok;
    n.key_q = key;
    n.bp_q = bat_in;
    n.rdata = '0;
    v = i_battery_voltage_sense;
    smp = i_batv_valid;
    low = smp && (v < pms_pkg::BATV_LOW);
    sec = (s.sec_cnt >= SEC_CYC - 24'h1);
    press = key && !s.key_q;
    enter = 1'b0;
    part = 1'b0;
    start = i_wr && (i_addr == pms_pkg::ADDR_CTRL) &&
            i_wdata[pms_pkg::CTRL_START];
    n.sec_cnt = sec ? '0 : s.sec_cnt + 24'h1;
    // ----------------------------------------------------------------
    // Switch status and prompt acknowledge
    // ----------------------------------------------------------------
    if (press) begin
      n.on = !s.on;
    end
    if (i_wr && (i_addr == pms_pkg::ADDR_CTRL) &&
        i_wdata[pms_pkg::CTRL_ACK]) begin
      n.prompt = 1'b0;
    end
    // ----------------------------------------------------------------
    // Operating mode
    // ----------------------------------------------------------------
    unique case (s.mode)
      pms_pkg::M_IDLE: begin
        n.mode = pms_pkg::M_OFF;
      end
      pms_pkg::M_OFF: begin
        if (s.av || s.on) begin
          n.mode = pms_pkg::M_BOOT;
          n.tmr = '0;
        end
      end
      pms_pkg::M_BOOT: begin
        n.tmr = s.tmr + 24'h1;
        if (s.tmr >= pms_pkg::BOOT_CYC - 24'h1) begin
          if (!i_firmware_valid || (s.on && up && right)) begin
            n.mode = pms_pkg::M_MASK;
          end else if (s.av && s.on) begin
            n.mode = pms_pkg::M_OPCHG;
            enter = 1'b1;
          end else if (s.av) begin
            n.mode = pms_pkg::M_CHARGE;
          end else if (s.on) begin
            n.mode = pms_pkg::M_OPER;
            n.tmr = '0;
            enter = 1'b1;
          end else begin
            n.mode = pms_pkg::M_OFF;
          end
        end
      end
      pms_pkg::M_MASK: begin
        // Stays until switched off, or off with the adapter gone
        if ((press && s.on) || (!s.on && !s.av)) begin
          n.mode = pms_pkg::M_OFF;
        end
      end
      pms_pkg::M_CHARGE: begin
        if (s.on) begin
          n.mode = pms_pkg::M_OPCHG;
          enter = 1'b1;
        end else if (!s.av) begin
          n.mode = pms_pkg::M_OFF;
        end
      end
      pms_pkg::M_OPCHG: begin
        if (!s.on) begin
          n.mode = s.av ? pms_pkg::M_CHARGE : pms_pkg::M_OFF;
        end else if (!s.av) begin
          // Converter already running, no start-up window
          n.mode = pms_pkg::M_OPER;
          n.tmr = FLY_CYC;
        end
      end
      pms_pkg::M_OPER: begin
        if (s.tmr < FLY_CYC) begin
          n.tmr = s.tmr + 24'h1;
        end
        if (s.tmr < FLY_CYC && low) begin
          n.mode = pms_pkg::M_OFF;
          n.on = 1'b0;
        end else if (!s.on) begin
          n.mode = pms_pkg::M_OFF;
        end else if (s.av) begin
          n.mode = pms_pkg::M_OPCHG;
        end
      end
      default: begin
        n.mode = pms_pkg::M_IDLE;
      end
    endcase
    if (enter && s.pend) begin
      n.prompt = 1'b1;
    end
    n.run = (n.mode == pms_pkg::M_OPER) ||
            (n.mode == pms_pkg::M_OPCHG);
    // ----------------------------------------------------------------
    // Charge current selection
    // ----------------------------------------------------------------
    chg_en = s.av && (s.rf != pms_pkg::R_DIS) &&
             ((s.mode == pms_pkg::M_CHARGE) ||
              (s.mode == pms_pkg::M_OPCHG));
    if (sec) begin
      n.chg_cnt = s.chg_cnt + 24'h1;
    end
    if (!chg_en) begin
      n.chg = pms_pkg::C_OFF;
    end else begin
      unique case (s.chg)
        pms_pkg::C_OFF, pms_pkg::C_DONE: begin
          if (smp && v < pms_pkg::BATV_FAST) begin
            n.chg = pms_pkg::C_FAST;
            n.chg_cnt = '0;
            n.peak = v;
            part = (v >= pms_pkg::BATV_LOW);
          end else if (smp) begin
            n.chg = pms_pkg::C_DONE;
          end
        end
        pms_pkg::C_FAST: begin
          if (smp && v > s.peak) begin
            n.peak = v;
          end
          // Falling voltage after the peak marks a full battery
          if ((smp && s.peak > v && s.peak - v >= pms_pkg::DV_DROP) ||
              s.chg_cnt >= FAST_S) begin
            n.chg = pms_pkg::C_TOPOFF;
            n.chg_cnt = '0;
          end
        end
        pms_pkg::C_TOPOFF: begin
          if (s.chg_cnt >= TOPOFF_S) begin
            n.chg = pms_pkg::C_TRICKLE;
            n.chg_cnt = '0;
          end
        end
        pms_pkg::C_TRICKLE: begin
          if (s.chg_cnt >= TRICKLE_S) begin
            n.chg = pms_pkg::C_DONE;
          end
        end
        default: begin
          n.chg = pms_pkg::C_OFF;
        end
      endcase
    end
    // ----------------------------------------------------------------
    // Battery refresh
    // ----------------------------------------------------------------
    if (sec && s.rf != pms_pkg::R_NONE) begin
      n.ref_cnt = s.ref_cnt + 24'h1;
    end
    unique case (s.rf)
      pms_pkg::R_NONE: begin
        if (start && s.mode == pms_pkg::M_OPCHG) begin
          n.rf = pms_pkg::R_CHG1;
          n.ref_cnt = '0;
          n.chg = pms_pkg::C_FAST;
          n.chg_cnt = '0;
          n.peak = '0;
        end
      end
      pms_pkg::R_CHG1: begin
        if (s.chg == pms_pkg::C_TRICKLE) begin
          n.rf = pms_pkg::R_DIS;
        end
      end
      pms_pkg::R_DIS: begin
        if (low) begin
          n.rf = pms_pkg::R_CHG2;
          n.chg = pms_pkg::C_FAST;
          n.chg_cnt = '0;
          n.peak = '0;
        end
      end
      pms_pkg::R_CHG2: begin
        if (s.chg == pms_pkg::C_TRICKLE) begin
          n.rf = pms_pkg::R_NONE;
          n.pend = 1'b0;
          n.pcyc = '0;
          n.month = '0;
        end
      end
    endcase
    // Leaving the mode or overrunning the limit abandons the refresh
    if (s.rf != pms_pkg::R_NONE &&
        (s.mode != pms_pkg::M_OPCHG || s.ref_cnt >= REFRESH_S)) begin
      n.rf = pms_pkg::R_NONE;
    end
    // ----------------------------------------------------------------
    // Refresh triggers, after the clear so a new event wins
    // ----------------------------------------------------------------
    if (part) begin
      if (s.pcyc >= pms_pkg::CYCLES_MAX - 8'h01) begin
        n.pcyc = '0;
        n.pend = 1'b1;
      end else begin
        n.pcyc = s.pcyc + 8'h01;
      end
    end
    if (sec) begin
      if (s.month >= MONTH3_S - 24'h1) begin
        n.month = '0;
        n.pend = 1'b1;
      end else begin
        n.month = s.month + 24'h1;
      end
    end
    if (s.bp_q && !bat_in) begin
      n.pend = 1'b1;
    end
    // ----------------------------------------------------------------
    // Charger gate and charge current request waveforms
    // ----------------------------------------------------------------
    n.gcnt = (s.gcnt >= pms_pkg::GATE_TOP) ? '0 : s.gcnt + 7'h01;
    n.gate = !chg_en || (s.gcnt >= s.duty);
    unique case (s.chg)
      pms_pkg::C_FAST: level = pms_pkg::REQ_FAST;
      pms_pkg::C_TOPOFF: level = pms_pkg::REQ_TOPOFF;
      pms_pkg::C_TRICKLE: level = pms_pkg::REQ_TRICKLE;
      pms_pkg::C_DONE: level = pms_pkg::REQ_NONE;
      default: level = pms_pkg::REQ_OFF;
    endcase
    n.rcnt = (s.rcnt >= pms_pkg::REQ_TOP) ? '0 : s.rcnt + 6'h01;
    n.req = (s.rcnt < level);
    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    if (i_wr && i_addr == pms_pkg::ADDR_DUTY) begin
      n.duty = i_wdata[6:0];
    end
    if (i_rd) begin
      unique case (i_addr)
        pms_pkg::ADDR_STAT: n.rdata = {3'h0, s.run, s.av, s.chg, s.rf,
                                       s.prompt, s.pend, s.on, s.mode};
        pms_pkg::ADDR_PCYC: n.rdata = {8'h00, s.pcyc};
        pms_pkg::ADDR_DUTY: n.rdata = {9'h000, s.duty};
        default: n.rdata = '0;
      endcase
    end
    // ----------------------------------------------------------------
    // Supply good low holds the controller in reset
    // ----------------------------------------------------------------
    if (!s.sg) begin
      n = RST;
      n.sg = bk_ok;
      n.av = ad_ok;
      n.key_q = key;
      n.bp_q = bat_in;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  assign o_rdata = s.rdata;
  assign o_supply_good = s.sg;
  assign o_adapter_valid = s.av;
  assign o_converter_run = s.run;
  assign o_charger_gate = s.gate;
  assign o_charge_current_request = s.req;
  assign o_refresh_prompt = s.prompt;
  assign o_mode = s.mode;
endmodule

// [test_power_mode_sequencer.sv]
// Self-checking testbench of the power mode sequencer
`timescale 1ns/1ps
module test_power_mode_sequencer;
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_onoff_key = 1'b0;
  logic i_key_up = 1'b0, i_key_right = 1'b0, i_firmware_valid = 1'b0;
  logic [11:0] rail_mv = 12'h000;
  logic [7:0] adapter_dv = 8'h00;
  logic [9:0] bat_cv = 10'h212;
  logic bat_fitted = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata, v;
  logic i_backup_rail_ok, i_adapter_ok, i_battery_present, i_batv_valid;
  logic [9:0] i_battery_voltage_sense;
  logic o_supply_good, o_adapter_valid, o_converter_run, o_charger_gate;
  logic o_charge_current_request, o_refresh_prompt;
  logic [2:0] o_mode;
  int miscompares = 0, tests_run = 0, n;
  // ----------------------------------------------------------------
  // Instances, short counts for simulation
  // ----------------------------------------------------------------
  pms_partner far (.i_ref_clk, .i_rail_mv(rail_mv), .i_adapter_dv(adapter_dv),
    .i_bat_cv(bat_cv), .i_bat_fitted(bat_fitted),
    .o_backup_rail_ok(i_backup_rail_ok), .o_adapter_ok(i_adapter_ok),
    .o_battery_present(i_battery_present), .o_batv_valid(i_batv_valid),
    .o_battery_voltage_sense(i_battery_voltage_sense));
  // Month, refresh and top-off keep long defaults, so only removal sets pend
  pms_top #(.DEB_CYC(24'h000004), .FLY_CYC(24'h000014), .SEC_CYC(24'h00000A),
    .FAST_S(24'h000014), .TRICKLE_S(24'h000005)) dut (.i_ref_clk,
    .i_sys_rst, .i_backup_rail_ok, .i_adapter_ok, .i_onoff_key, .i_key_up,
    .i_key_right, .i_battery_present, .i_firmware_valid, .i_batv_valid,
    .i_battery_voltage_sense, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_supply_good, .o_adapter_valid, .o_converter_run, .o_charger_gate,
    .o_charge_current_request, .o_refresh_prompt, .o_mode);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_mode(logic [2:0] m, int lim);
    int k;
    k = 0;
    while (o_mode !== m && k < lim) begin
      cyc(1);
      k++;
    end
    chk("mode", 16'(m), 16'(o_mode));
    if (o_mode !== m) give_verdict();
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic press();
    @(posedge i_ref_clk);
    i_onoff_key <= 1'b1;
    cyc(20);
    i_onoff_key <= 1'b0;
    cyc(20);
  endtask
  // Count gate lows or request highs over a window
  task automatic count(logic gate, int len);
    n = 0;
    repeat (len) begin
      cyc(1);
      n += gate ? int'(!o_charger_gate) : int'(o_charge_current_request);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    chk("idle", 16'h0003,
        16'({o_mode, o_charger_gate, o_charge_current_request}));
    rail_mv <= 12'hBB8;
    cyc(10);
    chk("supply good", 16'h0000, 16'(o_supply_good));
    rail_mv <= 12'hC1C;
    wait_mode(3'h1, 20);
    chk("supply good", 16'h0001, 16'(o_supply_good));
    i_onoff_key <= 1'b1;
    cyc(2);
    i_onoff_key <= 1'b0;
    cyc(150);
    chk("mode after glitch", 16'h0001, 16'(o_mode));
  endtask
  task automatic t_regs();
    rd(pms_pkg::ADDR_DUTY);
    chk("duty reset", 16'h0032, v);
    wr(pms_pkg::ADDR_DUTY, 16'h0028);
    rd(pms_pkg::ADDR_DUTY);
    chk("duty", 16'h0028, v);
    rd(4'h2);
    chk("unmapped", 16'h0000, v);
    wr(pms_pkg::ADDR_STAT, 16'hFFFF);
    rd(pms_pkg::ADDR_STAT);
    chk("status off", 16'h0001, v & 16'h1FEF);
  endtask
  task automatic t_mask(logic combo);
    i_firmware_valid <= combo;
    i_key_up <= combo;
    i_key_right <= combo;
    press();
    wait_mode(3'h2, 5);
    wait_mode(3'h3, 150);
    i_key_up <= 1'b0;
    i_key_right <= 1'b0;
    cyc(50);
    chk("mask stays", 16'h0006, 16'({o_mode, o_converter_run}));
    press();
    wait_mode(3'h1, 100);
  endtask
  task automatic t_charge();
    adapter_dv <= 8'h78;
    wait_mode(3'h2, 10);
    wait_mode(3'h4, 150);
    chk("run in charge", 16'h0000, 16'(o_converter_run));
    cyc(5);
    count(1'b1, 100);
    chk("gate low cycles", 16'h0028, 16'(n));
    bat_cv <= 10'h1F4;
    cyc(40);
    count(1'b0, 33);
    chk("fast request", 16'h0000, 16'(n));
    bat_cv <= 10'h1EF;
    cyc(20);
    rd(pms_pkg::ADDR_STAT);
    chk("top-off after drop", 16'h0002, 16'(v[10:8]));
    count(1'b0, 33);
    chk("top-off request", 16'h000F, 16'(n));
    rd(pms_pkg::ADDR_PCYC);
    chk("partial cycles", 16'h0001, v);
  endtask
  task automatic t_opchg();
    press();
    wait_mode(3'h5, 300);
    chk("run", 16'h0001, 16'(o_converter_run));
    wr(pms_pkg::ADDR_CTRL, 16'h0001);
    rd(pms_pkg::ADDR_STAT);
    chk("refresh phase", 16'h0001, 16'(v[7:6]));
    adapter_dv <= 8'h5A;
    wait_mode(3'h6, 300);
    chk("gate, valid", 16'h0002, 16'({o_charger_gate, o_adapter_valid}));
    rd(pms_pkg::ADDR_STAT);
    chk("refresh aborted", 16'h0000, 16'(v[7:6]));
  endtask
  task automatic t_prompt();
    bat_fitted <= 1'b0;
    cyc(20);
    bat_fitted <= 1'b1;
    press();
    wait_mode(3'h1, 50);
    cyc(50);
    chk("off holds", 16'h0001, 16'(o_mode));
    rd(pms_pkg::ADDR_STAT);
    chk("pending", 16'h0001, 16'(v[4]));
    press();
    wait_mode(3'h6, 300);
    chk("prompt", 16'h0001, 16'(o_refresh_prompt));
    wr(pms_pkg::ADDR_CTRL, 16'h0002);
    cyc(2);
    chk("prompt cleared", 16'h0000, 16'(o_refresh_prompt));
  endtask
  task automatic t_lowbat();
    press();
    wait_mode(3'h1, 50);
    bat_cv <= 10'h186;
    press();
    wait_mode(3'h6, 300);
    wait_mode(3'h1, 40);
    rd(pms_pkg::ADDR_STAT);
    chk("on bit cleared", 16'h0000, 16'(v[3]));
    rail_mv <= 12'h000;
    wait_mode(3'h0, 20);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    cyc(2);
    t_power();
    t_regs();
    t_mask(1'b0);
    t_mask(1'b1);
    t_charge();
    t_opchg();
    t_prompt();
    t_lowbat();
    give_verdict();
  end
endmodule
